/* tb/tb.sv */
// self-checking bench for the port-one transceiver register view
`timescale 1ns/1ns
`default_nettype none
module tb;
    // arbitrary identifier value, not a real code
    localparam logic [15:0] IDL = 16'h3c3c;
    logic        ref_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        ce_i      = 1'b1;
    logic [7:0]  addr_i    = 8'h00;
    logic [15:0] wr_data_i = 16'h0000;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic        an_c      = 1'b0;
    logic        lnk       = 1'b0;
    logic        an_f      = 1'b0;
    logic [15:0] rd_data_o;
    logic        lp, f100, anen, rs, ffd, fda, xalg, fxo, dxo, pd, dtx, dled, irq_o;
    int          errors    = 0;
    int          n_checks  = 0;
    logic [31:0] rows [13] = '{32'hfdff_793f, 32'h0000_0000, 32'h8480_0000, 32'h4000_4000,
        32'h2000_2000, 32'h1000_1000, 32'h0800_0800, 32'h0100_0100, 32'h0020_0020,
        32'h0010_0010, 32'h0008_0008, 32'h0002_0002, 32'h0005_0005};

    p1pr_regs #(.ADDR_W(8), .IDENT_LOW(IDL)) dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .ce_i(ce_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
        .rd_data_o(rd_data_o), .an_complete_i(an_c), .link_up_i(lnk), .an_failed_i(an_f),
        .far_end_loopback_o(lp), .speed_100_o(f100), .autoneg_enable_o(anen),
        .restart_an_o(rs), .forced_full_duplex_o(ffd), .forced_duplex_active_o(fda),
        .crossover_algorithm_select_o(xalg), .force_crossed_o(fxo),
        .auto_crossover_disable_o(dxo), .power_down_o(pd), .transmit_disable_o(dtx),
        .led_disable_o(dled), .irq_o(irq_o));

    always #5 ref_clk_i = ~ref_clk_i;

    // -------------------------------------------------------------------------
    // compare, bus and closing tasks
    // -------------------------------------------------------------------------
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask
    // control outputs packed in the same order as the expectation below
    task automatic chk_ctl(input logic [15:0] w);
        chk16({6'h00, lp, f100, anen, pd, ffd, xalg, fxo, dxo, dtx, dled},
              {6'h00, w[14], w[13], w[12], w[11], w[8], w[5], w[4], w[3], w[1], w[0]});
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        addr_i    <= a;
        wr_data_i <= d;
        wr_i      <= 1'b1;
        @(posedge ref_clk_i);
        wr_i      <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
        #1 chk16(rd_data_o, exp);
    endtask
    task automatic tally_and_finish;
        if (errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // -------------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        #1 chk_ctl(16'h1020);
        chk1(irq_o, 1'b0);
        rd(p1pr_pkg::OFS_CTRL, 16'h1020);
        rd(p1pr_pkg::OFS_STAT, 16'h7808);
        rd(p1pr_pkg::OFS_IDLO, IDL);
        foreach (rows[i])
        begin
            wr(p1pr_pkg::OFS_CTRL, rows[i][31:16]);
            chk_ctl(rows[i][15:0]);
            rd(p1pr_pkg::OFS_CTRL, rows[i][15:0]);
        end
        // restart pulses once and never sticks in the register
        wr(p1pr_pkg::OFS_CTRL, 16'h1200);
        chk1(rs, 1'b1);
        @(posedge ref_clk_i);
        #1 chk1(rs, 1'b0);
        rd(p1pr_pkg::OFS_CTRL, 16'h1000);
        chk1(fda, 1'b0);
        @(posedge ref_clk_i);
        an_f <= 1'b1;
        #1 chk1(fda, 1'b1);
        @(posedge ref_clk_i);
        an_f <= 1'b0;
        wr(p1pr_pkg::OFS_CTRL, 16'h0000);
        chk1(fda, 1'b1);
        // a write while the enable is low is lost
        @(posedge ref_clk_i);
        ce_i <= 1'b0;
        wr(p1pr_pkg::OFS_CTRL, 16'h4000);
        chk1(lp, 1'b0);
        @(posedge ref_clk_i);
        ce_i <= 1'b1;
        // second bank views share the same storage
        wr(p1pr_pkg::OFS_ALT_CTRL, 16'h8100);
        rd(p1pr_pkg::OFS_CTRL, 16'h4001);
        wr(p1pr_pkg::OFS_ALT_STAT, 16'h8000);
        rd(p1pr_pkg::OFS_CTRL, 16'h4021);
        rd(p1pr_pkg::OFS_ALT_CTRL, 16'h8100);
        rd(p1pr_pkg::OFS_ALT_STAT, 16'h8000);
        // status is read only; link event raises the interrupt
        wr(p1pr_pkg::OFS_STAT, 16'hffff);
        rd(p1pr_pkg::OFS_STAT, 16'h7808);
        wr(p1pr_pkg::OFS_IRQ_EN, 16'h0003);
        rd(p1pr_pkg::OFS_IRQ_EN, 16'h0003);
        @(posedge ref_clk_i);
        lnk <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        #1 chk1(irq_o, 1'b1);
        rd(p1pr_pkg::OFS_STAT, 16'h780c);
        rd(p1pr_pkg::OFS_IRQ_STAT, 16'h0001);
        wr(p1pr_pkg::OFS_IRQ_EN, 16'h0000);
        chk1(irq_o, 1'b0);
        wr(p1pr_pkg::OFS_IRQ_CLR, 16'h0001);
        rd(p1pr_pkg::OFS_IRQ_STAT, 16'h0000);
        rd(p1pr_pkg::OFS_IRQ_CLR, 16'h0000);
        @(posedge ref_clk_i);
        an_c <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        rd(p1pr_pkg::OFS_STAT, 16'h782c);
        rd(p1pr_pkg::OFS_IRQ_STAT, 16'h0004);
        rd(8'h3e, 16'h0000);
        // link loss raises its own event
        @(posedge ref_clk_i);
        lnk <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rd(p1pr_pkg::OFS_STAT, 16'h7828);
        rd(p1pr_pkg::OFS_IRQ_STAT, 16'h0006);
        tally_and_finish();
    end

    // a hang is cut well past the roughly 130 cycles the tests need
    initial
    begin
        repeat (5000) @(posedge ref_clk_i);
        errors++;
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire

/* verilog/p1pr_irq.sv */
// sticky event flags with enable mask and a level interrupt
`timescale 1ns/1ns
`default_nettype none
module p1pr_irq #(
    parameter int N = 3
) (
    // clock and control
    input  wire logic         ref_clk_i,
    input  wire logic         reset_n_i,
    input  wire logic         ce_i,
    // events and software access
    input  wire logic [N-1:0] set_i,
    input  wire logic         clr_wr_i,
    input  wire logic         en_wr_i,
    input  wire logic [N-1:0] data_i,
    // state
    output logic      [N-1:0] status_o,
    output logic      [N-1:0] enable_o,
    output logic              irq_o
);
    logic [N-1:0] status_r;
    logic [N-1:0] status_nxt;
    logic [N-1:0] enable_r;
    logic [N-1:0] clr_mask;

    // set beats clear so an event in the clearing cycle survives
    assign clr_mask   = clr_wr_i ? data_i : '0;
    assign status_nxt = (status_r & ~clr_mask) | set_i;

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            status_r <= '0;
            enable_r <= '0;
        end
        else if (ce_i)
        begin
            status_r <= status_nxt;
            if (en_wr_i)
                enable_r <= data_i;
        end
    end

    assign status_o = status_r;
    assign enable_o = enable_r;
    assign irq_o    = |(status_r & enable_r);
endmodule // p1pr_irq
`default_nettype wire

/* verilog/p1pr_pkg.sv */
// constants for the port-one transceiver control and status register view
// Notes on behaviour
// - basic control sits at offset 0x00 and its bits 15, 10 and 7 always read zero.
// - control bit 14 loops the second port's receive pair back through port one's media layers.
// - with negotiation off, control bit 13 picks 100 Mbps when one and 10 Mbps when zero, reset zero.
// - control bit 12 enables auto-negotiation and resets to one.
// - writing one to control bit 9 restarts auto-negotiation, and the bit resets to zero.
// - control bit 8 forces full duplex, applied only with negotiation off or failed.
// - control bit 5, reset one, picks the first crossover algorithm when one, the second when zero.
// - control bit 4 forces the crossed pairs and bit 3 disables automatic crossover, both reset zero.
// - control bits 11, 1 and 0 power down, disable transmit and disable the LED, all reset zero.
// - basic status at 0x02 is read only, bit 15 reads zero and bits 14 to 11 read one.
// - status bit 5 shows negotiation complete and bit 2 shows link up, both reset zero.
// - status bit 3 always reads one and bits 10 to 7 and 4 read zero.
// - status bits 0, 6 and 1 read zero.
// - a read-only word at 0x04 holds the low identifier constant.
package p1pr_pkg;
    // -------------------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STAT     = 8'h02;
    localparam logic [7:0] OFS_IDLO     = 8'h04;
    localparam logic [7:0] OFS_ALT_CTRL = 8'h10;
    localparam logic [7:0] OFS_ALT_STAT = 8'h12;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h22;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h24;
    // -------------------------------------------------------------------------
    // basic control bit positions
    // -------------------------------------------------------------------------
    localparam int C_LPBK = 14;
    localparam int C_F100 = 13;
    localparam int C_ANEN = 12;
    localparam int C_PD   = 11;
    localparam int C_RSAN = 9;
    localparam int C_FDX  = 8;
    localparam int C_XALG = 5;
    localparam int C_FXO  = 4;
    localparam int C_DXO  = 3;
    localparam int C_RSV  = 2;
    localparam int C_DTX  = 1;
    localparam int C_DLED = 0;
    // -------------------------------------------------------------------------
    // second bank control and status positions
    // -------------------------------------------------------------------------
    localparam int A_LPBK = 8;
    localparam int A_F100 = 6;
    localparam int A_ANEN = 7;
    localparam int A_PD   = 11;
    localparam int A_RSAN = 13;
    localparam int A_FDX  = 5;
    localparam int A_FXO  = 9;
    localparam int A_DXO  = 10;
    localparam int A_RSV  = 12;
    localparam int A_DTX  = 14;
    localparam int A_DLED = 15;
    localparam int A_XALG = 15;
    localparam int A_ANOK = 6;
    localparam int A_LINK = 5;
    // -------------------------------------------------------------------------
    // basic status layout
    // -------------------------------------------------------------------------
    localparam int S_ANOK = 5;
    localparam int S_LINK = 2;
    localparam logic [15:0] STAT_FIXED = 16'h7808;
    // -------------------------------------------------------------------------
    // reset values and interrupt events
    // -------------------------------------------------------------------------
    localparam logic RST_ANEN = 1'b1;
    localparam logic RST_XALG = 1'b1;
    localparam logic RST_OFF  = 1'b0;
    localparam int EV_LINK_UP = 0;
    localparam int EV_LINK_DN = 1;
    localparam int EV_AN_DONE = 2;
    localparam int EV_COUNT   = 3;
endpackage : p1pr_pkg

/* verilog/p1pr_regs.sv */
// port-one transceiver control, status and identifier registers
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module p1pr_regs #(
    parameter int          ADDR_W    = 8,
    // arbitrary neutral identifier value
    parameter logic [15:0] IDENT_LOW = 16'h5a5a
) (
    // clock, reset, enable
    input  wire logic              ref_clk_i,
    input  wire logic              reset_n_i,
    input  wire logic              ce_i,
    // register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [15:0]       wr_data_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [15:0]       rd_data_o,
    // transceiver state in
    input  wire logic              an_complete_i,
    input  wire logic              link_up_i,
    input  wire logic              an_failed_i,
    // transceiver control out
    output logic                   far_end_loopback_o,
    output logic                   speed_100_o,
    output logic                   autoneg_enable_o,
    output logic                   restart_an_o,
    output logic                   forced_full_duplex_o,
    output logic                   forced_duplex_active_o,
    output logic                   crossover_algorithm_select_o,
    output logic                   force_crossed_o,
    output logic                   auto_crossover_disable_o,
    output logic                   power_down_o,
    output logic                   transmit_disable_o,
    output logic                   led_disable_o,
    // interrupt
    output logic                   irq_o
);
    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    // pick the new value of a bit shared by two views
    function automatic logic shared_bit(
        input logic cur,
        input logic w_a,
        input logic d_a,
        input logic w_b,
        input logic d_b
    );
        shared_bit = w_a ? d_a : (w_b ? d_b : cur);
    endfunction

    function automatic logic hit(
        input logic [ADDR_W-1:0] a,
        input logic [7:0]        ofs
    );
        hit = (a == ADDR_W'(ofs));
    endfunction

    // -------------------------------------------------------------------------
    // decode
    // -------------------------------------------------------------------------
    wire logic wr_ctrl  = wr_i & ce_i & hit(addr_i, p1pr_pkg::OFS_CTRL);
    wire logic wr_actl  = wr_i & ce_i & hit(addr_i, p1pr_pkg::OFS_ALT_CTRL);
    wire logic wr_astat = wr_i & ce_i & hit(addr_i, p1pr_pkg::OFS_ALT_STAT);
    wire logic wr_ien   = wr_i & hit(addr_i, p1pr_pkg::OFS_IRQ_EN);
    wire logic wr_iclr  = wr_i & hit(addr_i, p1pr_pkg::OFS_IRQ_CLR);

    // -------------------------------------------------------------------------
    // shared control storage
    // -------------------------------------------------------------------------
    logic lpbk_r, f100_r, anen_r, pd_r, rsan_r, fdx_r;
    logic xalg_r, fxo_r, dxo_r, rsv_r, dtx_r, dled_r;
    logic lpbk_nxt, f100_nxt, anen_nxt, pd_nxt, rsan_nxt, fdx_nxt;
    logic xalg_nxt, fxo_nxt, dxo_nxt, rsv_nxt, dtx_nxt, dled_nxt;
    logic anok_r, link_r;

    assign lpbk_nxt = shared_bit(lpbk_r, wr_ctrl, wr_data_i[p1pr_pkg::C_LPBK],
                                 wr_actl, wr_data_i[p1pr_pkg::A_LPBK]);
    assign f100_nxt = shared_bit(f100_r, wr_ctrl, wr_data_i[p1pr_pkg::C_F100],
                                 wr_actl, wr_data_i[p1pr_pkg::A_F100]);
    assign anen_nxt = shared_bit(anen_r, wr_ctrl, wr_data_i[p1pr_pkg::C_ANEN],
                                 wr_actl, wr_data_i[p1pr_pkg::A_ANEN]);
    assign pd_nxt   = shared_bit(pd_r, wr_ctrl, wr_data_i[p1pr_pkg::C_PD],
                                 wr_actl, wr_data_i[p1pr_pkg::A_PD]);
    assign fdx_nxt  = shared_bit(fdx_r, wr_ctrl, wr_data_i[p1pr_pkg::C_FDX],
                                 wr_actl, wr_data_i[p1pr_pkg::A_FDX]);
    assign fxo_nxt  = shared_bit(fxo_r, wr_ctrl, wr_data_i[p1pr_pkg::C_FXO],
                                 wr_actl, wr_data_i[p1pr_pkg::A_FXO]);
    assign dxo_nxt  = shared_bit(dxo_r, wr_ctrl, wr_data_i[p1pr_pkg::C_DXO],
                                 wr_actl, wr_data_i[p1pr_pkg::A_DXO]);
    assign rsv_nxt  = shared_bit(rsv_r, wr_ctrl, wr_data_i[p1pr_pkg::C_RSV],
                                 wr_actl, wr_data_i[p1pr_pkg::A_RSV]);
    assign dtx_nxt  = shared_bit(dtx_r, wr_ctrl, wr_data_i[p1pr_pkg::C_DTX],
                                 wr_actl, wr_data_i[p1pr_pkg::A_DTX]);
    assign dled_nxt = shared_bit(dled_r, wr_ctrl, wr_data_i[p1pr_pkg::C_DLED],
                                 wr_actl, wr_data_i[p1pr_pkg::A_DLED]);
    // crossover select lives in the status word of the second bank
    assign xalg_nxt = shared_bit(xalg_r, wr_ctrl, wr_data_i[p1pr_pkg::C_XALG],
                                 wr_astat, wr_data_i[p1pr_pkg::A_XALG]);
    // restart is a one-cycle command, so the bit drops right after it fires
    assign rsan_nxt = (wr_ctrl & wr_data_i[p1pr_pkg::C_RSAN])
                    | (wr_actl & wr_data_i[p1pr_pkg::A_RSAN]);

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            lpbk_r <= p1pr_pkg::RST_OFF;
            f100_r <= p1pr_pkg::RST_OFF;
            anen_r <= p1pr_pkg::RST_ANEN;
            pd_r   <= p1pr_pkg::RST_OFF;
            rsan_r <= p1pr_pkg::RST_OFF;
            fdx_r  <= p1pr_pkg::RST_OFF;
            xalg_r <= p1pr_pkg::RST_XALG;
            fxo_r  <= p1pr_pkg::RST_OFF;
            dxo_r  <= p1pr_pkg::RST_OFF;
            rsv_r  <= p1pr_pkg::RST_OFF;
            dtx_r  <= p1pr_pkg::RST_OFF;
            dled_r <= p1pr_pkg::RST_OFF;
        end
        else if (ce_i)
        begin
            lpbk_r <= lpbk_nxt;
            f100_r <= f100_nxt;
            anen_r <= anen_nxt;
            pd_r   <= pd_nxt;
            rsan_r <= rsan_nxt;
            fdx_r  <= fdx_nxt;
            xalg_r <= xalg_nxt;
            fxo_r  <= fxo_nxt;
            dxo_r  <= dxo_nxt;
            rsv_r  <= rsv_nxt;
            dtx_r  <= dtx_nxt;
            dled_r <= dled_nxt;
        end
    end

    // -------------------------------------------------------------------------
    // mirrored transceiver state
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
        begin
            anok_r <= 1'b0;
            link_r <= 1'b0;
        end
        else if (ce_i)
        begin
            anok_r <= an_complete_i;
            link_r <= link_up_i;
        end
    end

    // -------------------------------------------------------------------------
    // register images
    // -------------------------------------------------------------------------
    logic [15:0] ctrl_img;
    logic [15:0] stat_img;
    logic [15:0] actl_img;
    logic [15:0] astat_img;

    // unsupported soft reset, isolate and collision test stay zero
    always_comb
    begin
        ctrl_img = 16'h0000;
        ctrl_img[p1pr_pkg::C_LPBK] = lpbk_r;
        ctrl_img[p1pr_pkg::C_F100] = f100_r;
        ctrl_img[p1pr_pkg::C_ANEN] = anen_r;
        ctrl_img[p1pr_pkg::C_PD]   = pd_r;
        ctrl_img[p1pr_pkg::C_RSAN] = rsan_r;
        ctrl_img[p1pr_pkg::C_FDX]  = fdx_r;
        ctrl_img[p1pr_pkg::C_XALG] = xalg_r;
        ctrl_img[p1pr_pkg::C_FXO]  = fxo_r;
        ctrl_img[p1pr_pkg::C_DXO]  = dxo_r;
        ctrl_img[p1pr_pkg::C_RSV]  = rsv_r;
        ctrl_img[p1pr_pkg::C_DTX]  = dtx_r;
        ctrl_img[p1pr_pkg::C_DLED] = dled_r;
    end

    always_comb
    begin
        stat_img = p1pr_pkg::STAT_FIXED;
        stat_img[p1pr_pkg::S_ANOK] = anok_r;
        stat_img[p1pr_pkg::S_LINK] = link_r;
    end

    always_comb
    begin
        actl_img = 16'h0000;
        actl_img[p1pr_pkg::A_LPBK] = lpbk_r;
        actl_img[p1pr_pkg::A_F100] = f100_r;
        actl_img[p1pr_pkg::A_ANEN] = anen_r;
        actl_img[p1pr_pkg::A_PD]   = pd_r;
        actl_img[p1pr_pkg::A_RSAN] = rsan_r;
        actl_img[p1pr_pkg::A_FDX]  = fdx_r;
        actl_img[p1pr_pkg::A_FXO]  = fxo_r;
        actl_img[p1pr_pkg::A_DXO]  = dxo_r;
        actl_img[p1pr_pkg::A_RSV]  = rsv_r;
        actl_img[p1pr_pkg::A_DTX]  = dtx_r;
        actl_img[p1pr_pkg::A_DLED] = dled_r;
    end

    always_comb
    begin
        astat_img = 16'h0000;
        astat_img[p1pr_pkg::A_XALG] = xalg_r;
        astat_img[p1pr_pkg::A_ANOK] = anok_r;
        astat_img[p1pr_pkg::A_LINK] = link_r;
    end

    // -------------------------------------------------------------------------
    // interrupt events
    // -------------------------------------------------------------------------
    logic [p1pr_pkg::EV_COUNT-1:0] ev_set;
    logic [p1pr_pkg::EV_COUNT-1:0] irq_stat;
    logic [p1pr_pkg::EV_COUNT-1:0] irq_en;

    // edges against the mirrored copy, so each link change and each rise of negotiation complete raises one event
    always_comb
    begin
        ev_set = '0;
        ev_set[p1pr_pkg::EV_LINK_UP] = link_up_i & ~link_r;
        ev_set[p1pr_pkg::EV_LINK_DN] = ~link_up_i & link_r;
        ev_set[p1pr_pkg::EV_AN_DONE] = an_complete_i & ~anok_r;
    end

    p1pr_irq #(
        .N (p1pr_pkg::EV_COUNT)
    ) u_irq (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .ce_i      (ce_i),
        .set_i     (ev_set),
        .clr_wr_i  (wr_iclr),
        .en_wr_i   (wr_ien),
        .data_i    (wr_data_i[p1pr_pkg::EV_COUNT-1:0]),
        .status_o  (irq_stat),
        .enable_o  (irq_en),
        .irq_o     (irq_o)
    );

    // -------------------------------------------------------------------------
    // read port
    // -------------------------------------------------------------------------
    logic [15:0] rd_mux;
    logic [15:0] rd_data_r;
    logic [15:0] rd_data_nxt;

    // clear register is write only and reads zero like any unmapped word
    always_comb
    begin
        rd_mux = 16'h0000;
        if (hit(addr_i, p1pr_pkg::OFS_CTRL))
            rd_mux = ctrl_img;
        else if (hit(addr_i, p1pr_pkg::OFS_STAT))
            rd_mux = stat_img;
        else if (hit(addr_i, p1pr_pkg::OFS_IDLO))
            rd_mux = IDENT_LOW;
        else if (hit(addr_i, p1pr_pkg::OFS_ALT_CTRL))
            rd_mux = actl_img;
        else if (hit(addr_i, p1pr_pkg::OFS_ALT_STAT))
            rd_mux = astat_img;
        else if (hit(addr_i, p1pr_pkg::OFS_IRQ_STAT))
            rd_mux = {{(16-p1pr_pkg::EV_COUNT){1'b0}}, irq_stat};
        else if (hit(addr_i, p1pr_pkg::OFS_IRQ_EN))
            rd_mux = {{(16-p1pr_pkg::EV_COUNT){1'b0}}, irq_en};
    end

    assign rd_data_nxt = rd_i ? rd_mux : 16'h0000;

    always_ff @(posedge ref_clk_i)
    begin
        if (!reset_n_i)
            rd_data_r <= 16'h0000;
        else if (ce_i)
            rd_data_r <= rd_data_nxt;
    end

    assign rd_data_o = rd_data_r;

    // -------------------------------------------------------------------------
    // control outputs
    // -------------------------------------------------------------------------
    assign far_end_loopback_o           = lpbk_r;
    assign autoneg_enable_o             = anen_r;
    assign speed_100_o                  = f100_r;
    assign restart_an_o                 = rsan_r;
    assign forced_full_duplex_o         = fdx_r;
    assign forced_duplex_active_o       = ~anen_r | an_failed_i;
    assign crossover_algorithm_select_o = xalg_r;
    assign force_crossed_o              = fxo_r;
    assign auto_crossover_disable_o     = dxo_r;
    assign power_down_o                 = pd_r;
    assign transmit_disable_o           = dtx_r;
    assign led_disable_o                = dled_r;

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    wire logic rd_ctrl_q = rd_i & ce_i & hit(addr_i, p1pr_pkg::OFS_CTRL);
    wire logic rd_stat_q = rd_i & ce_i & hit(addr_i, p1pr_pkg::OFS_STAT);
    wire logic rd_id_q   = rd_i & ce_i & hit(addr_i, p1pr_pkg::OFS_IDLO);

    AST_CTRL_RO_ZERO: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        rd_ctrl_q |=> (rd_data_o[15] == 1'b0 && rd_data_o[10] == 1'b0 && rd_data_o[7] == 1'b0))
        else $error("unsupported control bits read nonzero");

    AST_LOOPBACK: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (wr_ctrl && wr_data_i[p1pr_pkg::C_LPBK]) |=> far_end_loopback_o)
        else $error("loopback not applied after write");

    AST_SPEED_FORCE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (wr_ctrl && !wr_data_i[p1pr_pkg::C_ANEN]) |=>
        (!autoneg_enable_o && speed_100_o == $past(wr_data_i[p1pr_pkg::C_F100])))
        else $error("forced speed does not follow write");

    AST_AN_AFTER_RESET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        $rose(reset_n_i) |-> (autoneg_enable_o && !speed_100_o && !power_down_o))
        else $error("wrong control state after reset");

    AST_RESTART_PULSE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (wr_ctrl && wr_data_i[p1pr_pkg::C_RSAN]) ##1 (ce_i && !wr_i) |->
        restart_an_o ##1 !restart_an_o)
        else $error("restart pulse wrong");

    AST_DUPLEX_FORCE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (wr_ctrl && !wr_data_i[p1pr_pkg::C_ANEN] && wr_data_i[p1pr_pkg::C_FDX]) |=>
        (forced_full_duplex_o && forced_duplex_active_o))
        else $error("forced duplex not active");

    AST_STATUS_FIXED: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        rd_stat_q |=> ((rd_data_o & 16'hffdb) == 16'h7808))
        else $error("fixed status bits wrong");

    AST_STATUS_LIVE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        rd_stat_q |=> (rd_data_o[p1pr_pkg::S_LINK] == $past(link_r)
                    && rd_data_o[p1pr_pkg::S_ANOK] == $past(anok_r)))
        else $error("live status bits wrong");

    AST_IDENT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        rd_id_q |=> (rd_data_o == IDENT_LOW))
        else $error("identifier word wrong");

    AST_TWIN_VIEW: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        wr_actl |=> (far_end_loopback_o == $past(wr_data_i[p1pr_pkg::A_LPBK])
                  && led_disable_o == $past(wr_data_i[p1pr_pkg::A_DLED])))
        else $error("second view write not shared");

    AST_CROSSOVER: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        wr_ctrl |=> (force_crossed_o == $past(wr_data_i[p1pr_pkg::C_FXO])
                  && auto_crossover_disable_o == $past(wr_data_i[p1pr_pkg::C_DXO])
                  && crossover_algorithm_select_o == $past(wr_data_i[p1pr_pkg::C_XALG])))
        else $error("crossover controls wrong");
endmodule // p1pr_regs
`default_nettype wire
